// >>> rtl/nfhc_pkg.sv
// package for the nand flash host controller
package nfhc_pkg;
  // command codes
  localparam logic [7:0] CMD_READ1    = 8'h00;
  localparam logic [7:0] CMD_READ2    = 8'h30;
  localparam logic [7:0] CMD_PROG1    = 8'h80;
  localparam logic [7:0] CMD_PROG2    = 8'h10;
  localparam logic [7:0] CMD_MPROG    = 8'h11;
  localparam logic [7:0] CMD_MPROG1   = 8'h81;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_STATUS_M = 8'h71;
  localparam logic [7:0] CMD_ECC      = 8'h7A;
  localparam logic [7:0] CMD_RESET    = 8'hFF;
  // operation kinds requested by the user side
  typedef enum logic [1:0] {
    NFHC_K_CMD  = 2'b00,
    NFHC_K_ADDR = 2'b01,
    NFHC_K_WDAT = 2'b10,
    NFHC_K_RDAT = 2'b11
  } nfhc_kind_t;
  typedef struct packed {
    nfhc_kind_t kind;
    logic [7:0] data;
  } nfhc_req_t;
  // pins towards the device
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nfhc_pins_t;
  // timing at 100 MHz
  localparam int CLK_NS        = 10;
  localparam int STROBE_LOW_NS = 20;
  localparam int STROBE_HI_NS  = 20;
  localparam int WHR_NS        = 60;
  localparam int WB_NS         = 100;
  localparam int STROBE_LOW_CY = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HI_CY  = (STROBE_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CY        = (WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CY         = (WB_NS + CLK_NS - 1) / CLK_NS;
  // longest busy the host tolerates: 700 us program, cycles
  localparam int BUSY_MAX_US   = 700;
  localparam int BUSY_MAX_CY   = BUSY_MAX_US * 1000 / CLK_NS;
  localparam int PARTIAL_MAX   = 4;
  localparam int ECC_BYTES     = 4;
endpackage : nfhc_pkg

// >>> rtl/nfhc_fifo.sv
// small valid/ready fifo
`timescale 1ns/10ps
module nfhc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("bad fifo width or depth");
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;
  always_comb begin
    in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    out_valid = wr_q != rd_q;
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    out_data = mem_q[rd_q[AW-1:0]];
    wr_d     = push ? wr_q + 1'b1 : wr_q;
    rd_d     = pop ? rd_q + 1'b1 : rd_q;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : nfhc_fifo

// >>> rtl/nfhc_host.sv
// nand flash host controller: drives command, address and data strobes
// How it works
// - host counts program confirms (10h), refuses a fifth 80h until a reset (FFh) or read (00h) command.
// - after 7Ah host reads four ecc status bytes.
// - 7Ah only accepted right after a read busy ends.
// - status command 70h or 71h then one strobe returns status.
`timescale 1ns/10ps
module nfhc_host #(
  parameter int BUSY_MAX_CY = nfhc_pkg::BUSY_MAX_CY
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               clk_en,
  // user requests
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire nfhc_pkg::nfhc_req_t req,
  // read data to user
  output logic                    rd_valid,
  input  wire logic               rd_ready,
  output logic [7:0]              rd_data,
  // status
  output logic                    busy_seen,
  output logic                    timeout,
  output logic                    refused,
  // device pins
  output nfhc_pkg::nfhc_pins_t    pins,
  input  wire logic [7:0]         io_in,
  input  wire logic               ready_busy_n
);
  if (BUSY_MAX_CY < 1) $error("busy bound must be positive");
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_LOW   = 3'b001,
    S_HIGH  = 3'b010,
    S_WB    = 3'b011,
    S_BUSY  = 3'b100
  } nfhc_state_t;

  // ready line synchroniser, three stages
  logic [2:0] rb_sync_q;
  logic       rb_q, rb_d;
  always_comb begin
    rb_d = (rb_sync_q[1] == rb_sync_q[2]) ? rb_sync_q[2] : rb_q;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rb_sync_q <= 3'b111;
      rb_q      <= 1'b1;
    end else if (clk_en) begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_n};
      rb_q      <= rb_d;
    end
  end

  // read data buffer
  logic       f_in_valid, f_in_ready;
  logic [7:0] f_in_data;
  nfhc_fifo #(.WIDTH(8), .DEPTH(4)) u_rdfifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  nfhc_state_t          st_q, st_d;
  nfhc_pkg::nfhc_req_t  cur_q, cur_d;
  nfhc_pkg::nfhc_pins_t pins_q, pins_d;
  logic [31:0] cnt_q, cnt_d;
  logic [7:0]  last_cmd_q, last_cmd_d;
  logic [2:0]  prog_cnt_q, prog_cnt_d;
  logic [2:0]  ecc_left_q, ecc_left_d;
  logic        after_read_q, after_read_d;
  logic        timeout_q, timeout_d, refused_q, refused_d, busy_q, busy_d;
  logic        f_valid_q, f_valid_d;
  logic [7:0]  f_data_q, f_data_d;
  logic        is_cmd, allowed, waits;

  function automatic logic cmd_waits(input logic [7:0] c);
    cmd_waits = (c == nfhc_pkg::CMD_READ2) || (c == nfhc_pkg::CMD_PROG2) ||
                (c == nfhc_pkg::CMD_MPROG) || (c == nfhc_pkg::CMD_RESET);
  endfunction : cmd_waits

  always_comb begin
    st_d         = st_q;
    cur_d        = cur_q;
    pins_d       = pins_q;
    cnt_d        = cnt_q;
    last_cmd_d   = last_cmd_q;
    prog_cnt_d   = prog_cnt_q;
    ecc_left_d   = ecc_left_q;
    after_read_d = after_read_q;
    timeout_d    = 1'b0;
    refused_d    = 1'b0;
    busy_d       = !rb_q;
    f_valid_d    = f_valid_q && !f_in_ready;
    f_data_d     = f_data_q;
    is_cmd       = req.kind == nfhc_pkg::NFHC_K_CMD;
    allowed      = 1'b1;
    if (!rb_q && !(is_cmd && (req.data == nfhc_pkg::CMD_STATUS ||
        req.data == nfhc_pkg::CMD_STATUS_M || req.data == nfhc_pkg::CMD_RESET)) &&
        !(req.kind == nfhc_pkg::NFHC_K_RDAT && (last_cmd_q == nfhc_pkg::CMD_STATUS ||
        last_cmd_q == nfhc_pkg::CMD_STATUS_M))) begin
      allowed = 1'b0;
    end
    if (is_cmd && req.data == nfhc_pkg::CMD_ECC && !after_read_q) begin
      allowed = 1'b0;
    end
    if (is_cmd && req.data == nfhc_pkg::CMD_PROG1 &&
        prog_cnt_q >= 3'(nfhc_pkg::PARTIAL_MAX)) begin
      allowed = 1'b0;
    end
    // pending ecc bytes block other commands
    if (ecc_left_q != 3'd0 && req.kind != nfhc_pkg::NFHC_K_RDAT) begin
      allowed = 1'b0;
    end
    waits = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (req_valid && !f_valid_q) begin
          if (!allowed) begin
            refused_d = 1'b1;
          end else begin
            cur_d          = req;
            st_d           = S_LOW;
            cnt_d          = 32'(nfhc_pkg::STROBE_LOW_CY);
            pins_d.ce_n    = 1'b0;
            pins_d.cle     = is_cmd;
            pins_d.ale     = req.kind == nfhc_pkg::NFHC_K_ADDR;
            pins_d.io_out  = req.data;
            if (req.kind == nfhc_pkg::NFHC_K_RDAT) begin
              pins_d.read_strobe_n = 1'b0;
              pins_d.io_oe         = 1'b0;
            end else begin
              pins_d.we_n  = 1'b0;
              pins_d.io_oe = 1'b1;
            end
          end
        end
      end
      S_LOW: begin
        cnt_d = cnt_q - 32'd1;
        if (cnt_q <= 32'd1) begin
          st_d  = S_HIGH;
          cnt_d = 32'(nfhc_pkg::STROBE_HI_CY);
          pins_d.we_n = 1'b1;
          if (cur_q.kind == nfhc_pkg::NFHC_K_RDAT) begin
            pins_d.read_strobe_n = 1'b1;
            f_valid_d            = 1'b1;
            f_data_d             = io_in;
            after_read_d         = 1'b0;
            if (ecc_left_q != 3'd0) begin
              ecc_left_d = ecc_left_q - 3'd1;
            end
          end
          if (cur_q.kind == nfhc_pkg::NFHC_K_CMD) begin
            last_cmd_d = cur_q.data;
            after_read_d = 1'b0;
            // status byte follows on the next strobe
            if (cur_q.data == nfhc_pkg::CMD_STATUS || cur_q.data == nfhc_pkg::CMD_STATUS_M ||
                cur_q.data == nfhc_pkg::CMD_ECC) begin
              cnt_d = 32'(nfhc_pkg::WHR_CY);
            end
            if (cur_q.data == nfhc_pkg::CMD_ECC) begin
              ecc_left_d = 3'(nfhc_pkg::ECC_BYTES);
            end
            if (cur_q.data == nfhc_pkg::CMD_PROG2) begin
              prog_cnt_d = prog_cnt_q + 3'd1;
            end
            if (cur_q.data == nfhc_pkg::CMD_RESET || cur_q.data == nfhc_pkg::CMD_READ1) begin
              prog_cnt_d = 3'd0;
            end
          end
        end
      end
      S_HIGH: begin
        cnt_d = cnt_q - 32'd1;
        if (cnt_q <= 32'd1) begin
          pins_d.cle   = 1'b0;
          pins_d.ale   = 1'b0;
          pins_d.io_oe = 1'b0;
          waits = cur_q.kind == nfhc_pkg::NFHC_K_CMD && cmd_waits(cur_q.data);
          st_d  = waits ? S_WB : S_IDLE;
          cnt_d = 32'(nfhc_pkg::WB_CY);
        end
      end
      S_WB: begin
        cnt_d = cnt_q - 32'd1;
        if (cnt_q <= 32'd1) begin
          st_d  = S_BUSY;
          cnt_d = 32'(BUSY_MAX_CY);
        end
      end
      S_BUSY: begin
        cnt_d = cnt_q - 32'd1;
        if (rb_q) begin
          st_d = S_IDLE;
          after_read_d = last_cmd_q == nfhc_pkg::CMD_READ2;
        end else if (cnt_q <= 32'd1) begin
          st_d      = S_IDLE;
          timeout_d = 1'b1;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q         <= S_IDLE;
      cur_q        <= '0;
      pins_q       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                        read_strobe_n: 1'b1, io_out: 8'h00, io_oe: 1'b0};
      cnt_q        <= '0;
      last_cmd_q   <= 8'h00;
      prog_cnt_q   <= '0;
      ecc_left_q   <= '0;
      after_read_q <= 1'b0;
      timeout_q    <= 1'b0;
      refused_q    <= 1'b0;
      busy_q       <= 1'b0;
      f_valid_q    <= 1'b0;
      f_data_q     <= 8'h00;
    end else if (clk_en) begin
      st_q         <= st_d;
      cur_q        <= cur_d;
      pins_q       <= pins_d;
      cnt_q        <= cnt_d;
      last_cmd_q   <= last_cmd_d;
      prog_cnt_q   <= prog_cnt_d;
      ecc_left_q   <= ecc_left_d;
      after_read_q <= after_read_d;
      timeout_q    <= timeout_d;
      refused_q    <= refused_d;
      busy_q       <= busy_d;
      f_valid_q    <= f_valid_d;
      f_data_q     <= f_data_d;
    end
  end

  assign f_in_valid = f_valid_q;
  assign f_in_data  = f_data_q;
  assign req_ready  = (st_q == S_IDLE) && !f_valid_q && clk_en;
  assign pins       = pins_q;
  assign timeout    = timeout_q;
  assign refused    = refused_q;
  assign busy_seen  = busy_q;

  chk_cmd_cle: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(pins_q.we_n) && cur_q.kind == nfhc_pkg::NFHC_K_CMD |-> pins_q.cle)
    else $error("command latched without cle");
  chk_busy_gate: assert property (@(posedge clk_sys) disable iff (reset)
    st_q == S_IDLE && clk_en && req_valid && !f_valid_q && !rb_q &&
    (req.kind == nfhc_pkg::NFHC_K_ADDR || req.kind == nfhc_pkg::NFHC_K_WDAT) |=> refused_q)
    else $error("non-command sent while busy");
  chk_partial_max: assert property (@(posedge clk_sys) disable iff (reset)
    prog_cnt_q <= 3'(nfhc_pkg::PARTIAL_MAX))
    else $error("page programmed too often");
  chk_strobe_high: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
    $rose(pins_q.read_strobe_n) |-> pins_q.read_strobe_n [*2])
    else $error("read strobe high too short");
  chk_ecc_count: assert property (@(posedge clk_sys) disable iff (reset)
    ecc_left_q != 3'd0 && st_q == S_IDLE && clk_en && req_valid && !f_valid_q &&
    req.kind != nfhc_pkg::NFHC_K_RDAT |=> refused_q && ecc_left_q <= 3'(nfhc_pkg::ECC_BYTES))
    else $error("ecc bytes skipped");
  // busy wait ends on ready or timeout
  chk_busy_exit: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
    st_q == S_BUSY && rb_q |=> st_q == S_IDLE && !timeout_q)
    else $error("busy wait did not end on ready");
  chk_status_gap: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
    $rose(pins_q.we_n) && pins_q.cle && cur_q.data == nfhc_pkg::CMD_STATUS
    |-> pins_q.read_strobe_n [*6])
    else $error("status strobe too early");
  // read data captured at strobe rise
  chk_read_cap: assert property (@(posedge clk_sys) disable iff (reset || !clk_en)
    $rose(pins_q.read_strobe_n) |-> f_valid_q)
    else $error("read byte not captured");
endmodule : nfhc_host

// >>> tb/nfhc_dev_model.sv
// behavioural nand flash device facing the host controller
`timescale 1ns/10ps
module nfhc_dev_model #(
  parameter int PROG_CY  = 60,
  parameter int SHORT_CY = 3,
  parameter int READ_CY  = 20,
  parameter int RST_CY   = 5
) (
  // clock and test control
  input  wire logic                 clk_sys,
  input  wire logic                 slow,
  // pins from the host
  input  wire nfhc_pkg::nfhc_pins_t pins,
  // pins to the host
  output logic [7:0]                dev_io,
  output logic                      ready_busy_n
);
  int         busy_cnt = 0;
  int         idx      = 0;
  int         mul;
  logic [1:0] mode     = 2'h0;
  logic       we_q     = 1'b1;
  logic       rs_q     = 1'b1;
  logic       cle_q    = 1'b0;
  logic       ce_q     = 1'b1;
  logic [7:0] val;

  initial dev_io = 8'h5A;
  assign mul = slow ? 10 : 1;
  // open drain busy line, pulled up when idle
  assign ready_busy_n = (busy_cnt == 0);

  always @(posedge clk_sys) begin
    we_q <= pins.we_n;
    rs_q <= pins.read_strobe_n;
    cle_q <= pins.cle;
    ce_q <= pins.ce_n;
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    // command latched on rising write strobe
    if (!we_q && pins.we_n && pins.cle && !pins.ce_n) begin
      case (pins.io_out)
        nfhc_pkg::CMD_READ1: begin idx <= 0; mode <= 2'h0; end
        nfhc_pkg::CMD_READ2: busy_cnt <= READ_CY * mul;
        nfhc_pkg::CMD_PROG2: busy_cnt <= PROG_CY * mul;
        nfhc_pkg::CMD_MPROG: busy_cnt <= SHORT_CY;
        nfhc_pkg::CMD_RESET: begin busy_cnt <= RST_CY; mode <= 2'h0; end
        // status byte on next read strobe
        nfhc_pkg::CMD_STATUS, nfhc_pkg::CMD_STATUS_M: mode <= 2'h1;
        nfhc_pkg::CMD_ECC: begin idx <= 0; mode <= 2'h2; end
        default: ;
      endcase
    end
    // status, ecc or page byte after strobe falls
    if (rs_q && !pins.read_strobe_n && !pins.ce_n) begin
      val = (mode == 2'h1) ? {1'b1, ready_busy_n, 6'h00} :
            (mode == 2'h2) ? 8'h10 + idx[7:0] : 8'hA5 ^ idx[7:0];
      idx <= idx + 1;
      dev_io <= #2 val;
    end
    // release after hold on strobe rise or latch or select change
    if ((!rs_q && pins.read_strobe_n) || (!cle_q && pins.cle) || (!ce_q && pins.ce_n) ||
        (we_q && !pins.we_n))
      dev_io <= #16 ~dev_io;
  end
endmodule : nfhc_dev_model

// >>> tb/test_nfhc_host.sv
// self-checking bench for the nand flash host controller
`timescale 1ns/10ps
module test_nfhc_host;
  logic                 clk_sys   = 1'b0;
  logic                 reset     = 1'b1;
  logic                 req_valid = 1'b0;
  logic                 rd_ready  = 1'b0;
  logic                 slow      = 1'b0;
  logic                 stall     = 1'b0;
  logic                 clk_en    = 1'b1;
  nfhc_pkg::nfhc_req_t  req       = '0;
  logic                 req_ready, rd_valid, busy_seen, timeout, refused, ready_busy_n;
  logic [7:0]           rd_data, dev_io, io_in;
  nfhc_pkg::nfhc_pins_t pins;
  logic [7:0]           exp_q[$];
  logic [31:0]          rng       = 32'hE778;
  int                   fails     = 0;
  int                   samples_checked = 0;
  int                   n_ref = 0, n_to = 0, n_busy = 0;

  always #5 clk_sys = ~clk_sys;
  assign io_in = pins.io_oe ? pins.io_out : dev_io;

  nfhc_host #(.BUSY_MAX_CY(200)) dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .busy_seen(busy_seen), .timeout(timeout), .refused(refused),
    .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nfhc_dev_model model (
    .clk_sys(clk_sys), .slow(slow), .pins(pins), .dev_io(dev_io),
    .ready_busy_n(ready_busy_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // pulse counters and read data checker
  always @(posedge clk_sys) begin
    rng <= xs(rng);
    rd_ready <= #1 ~stall & rng[3];
    if (refused === 1'b1) n_ref++;
    if (timeout === 1'b1) n_to++;
    if (busy_seen === 1'b1) n_busy++;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("rd_extra", 0, 1);
      else chk("rd_data", exp_q.pop_front(), rd_data);
    end
  end

  task automatic send(input nfhc_pkg::nfhc_kind_t k, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req = '{kind: k, data: d};
    while (req_ready !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 3000) chk("req_ready", 1, 0);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
  endtask : send

  task automatic cmd(input logic [7:0] c);
    send(nfhc_pkg::NFHC_K_CMD, c);
  endtask : cmd

  task automatic page(input logic [7:0] c);
    cmd(c);
    repeat (5) send(nfhc_pkg::NFHC_K_ADDR, rng[7:0]);
  endtask : page

  task automatic prog(input logic [7:0] fin);
    page(nfhc_pkg::CMD_PROG1);
    send(nfhc_pkg::NFHC_K_WDAT, rng[15:8]);
    cmd(fin);
  endtask : prog

  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    send(nfhc_pkg::NFHC_K_RDAT, 8'h00);
  endtask : rd

  initial begin
    #500000;
    fails++;
    $display("Error watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    int n;
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    // fifth program of a page refused
    repeat (4) prog(nfhc_pkg::CMD_PROG2);
    cmd(nfhc_pkg::CMD_PROG1);
    repeat (4) @(posedge clk_sys);
    chk("refused", 1, n_ref);
    chk("busy_seen", 1, n_busy > 0);
    chk("timeout", 0, n_to);
    $display("test partial program done");
    cmd(nfhc_pkg::CMD_RESET);
    prog(nfhc_pkg::CMD_MPROG);
    page(nfhc_pkg::CMD_MPROG1);
    send(nfhc_pkg::NFHC_K_WDAT, rng[7:0]);
    cmd(nfhc_pkg::CMD_PROG2);
    repeat (4) @(posedge clk_sys);
    chk("timeout", 0, n_to);
    chk("refused", 1, n_ref);
    $display("test multi plane done");
    // device too slow, busy wait gives up
    slow = 1'b1;
    prog(nfhc_pkg::CMD_PROG2);
    repeat (250) @(posedge clk_sys);
    chk("timeout", 1, n_to);
    send(nfhc_pkg::NFHC_K_ADDR, rng[7:0]);
    repeat (4) @(posedge clk_sys);
    chk("refused", 2, n_ref);
    cmd(nfhc_pkg::CMD_STATUS);
    rd(8'h80);
    slow = 1'b0;
    cmd(nfhc_pkg::CMD_RESET);
    $display("test busy timeout done");
    // page read with consumer stalled so the fifo fills
    stall = 1'b1;
    fork
      begin
        repeat (100) @(posedge clk_sys);
        #1;
        stall = 1'b0;
      end
    join_none
    page(nfhc_pkg::CMD_READ1);
    cmd(nfhc_pkg::CMD_READ2);
    for (int i = 0; i < 6; i++) rd(8'hA5 ^ i[7:0]);
    $display("test page read done");
    // ecc status after read, then a late request refused
    page(nfhc_pkg::CMD_READ1);
    cmd(nfhc_pkg::CMD_READ2);
    cmd(nfhc_pkg::CMD_ECC);
    for (int i = 0; i < 2; i++) rd(8'h10 + i[7:0]);
    cmd(nfhc_pkg::CMD_STATUS);
    repeat (4) @(posedge clk_sys);
    chk("refused", 3, n_ref);
    for (int i = 2; i < 4; i++) rd(8'h10 + i[7:0]);
    cmd(nfhc_pkg::CMD_ECC);
    repeat (4) @(posedge clk_sys);
    chk("refused", 4, n_ref);
    $display("test ecc status done");
    // both status codes, the first frozen mid strobe
    fork
      begin
        nfhc_pkg::nfhc_pins_t p0;
        repeat (3) @(posedge clk_sys);
        #1;
        clk_en = 1'b0;
        p0 = pins;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("clk_en_hold", p0, pins);
        clk_en = 1'b1;
      end
    join_none
    cmd(nfhc_pkg::CMD_STATUS);
    rd(8'hC0);
    cmd(nfhc_pkg::CMD_STATUS_M);
    rd(8'hC0);
    n = 0;
    while (exp_q.size() > 0 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    chk("queue", 0, exp_q.size());
    $display("test status read done");
    end_of_test();
  end
endmodule : test_nfhc_host
